// [rtl/swo_pkg.sv]
// Purpose: constants and types shared by the switched output controller
// Assumes: 32-bit classic Wishbone, word-aligned byte addresses
// Notes: powers in watts, times in minutes
package swo_pkg;
    localparam int NCH = 4;
    localparam int PW_W = 20;
    localparam int SOC_W = 7;
    localparam int CNT_W = 11;
    localparam int EV_W = 8;
    localparam int ADR_W = 8;

    // global registers
    localparam logic [ADR_W-1:0] ADR_SOC = 8'h00;
    localparam logic [ADR_W-1:0] ADR_STATE = 8'h04;
    localparam logic [ADR_W-1:0] ADR_IRQ_STAT = 8'h08;
    localparam logic [ADR_W-1:0] ADR_IRQ_CLR = 8'h0c;
    localparam logic [ADR_W-1:0] ADR_IRQ_EN = 8'h10;
    // per-output block: base + channel * stride
    localparam logic [ADR_W-1:0] ADR_CH_BASE = 8'h40;
    localparam int CH_SHIFT = 4;
    localparam logic [1:0] SUB_CFG = 2'h0;
    localparam logic [1:0] SUB_P1 = 2'h1;
    localparam logic [1:0] SUB_P2 = 2'h2;
    localparam logic [1:0] SUB_TIM = 2'h3;

    // cfg fields
    localparam int CFG_MODE_LO = 0;
    localparam int CFG_POL = 3;
    localparam int CFG_BASIS = 4;
    localparam int CFG_FUNC = 5;
    localparam int CFG_HOLD = 6;
    localparam int CFG_EXT = 7;
    localparam int CFG_LIM_LO = 8;
    localparam int CFG_EV_LO = 16;
    // tim fields
    localparam int TIM_T1_LO = 0;
    localparam int TIM_T1_W = 10;
    localparam int TIM_T2_LO = 16;
    localparam int TIM_T2_W = 11;
    // soc fields
    localparam int SOC_ON_LO = 0;
    localparam int SOC_FLOOR_LO = 8;

    localparam logic [2:0] MODE_OFF = 3'h0;
    localparam logic [2:0] MODE_LOAD = 3'h1;
    localparam logic [2:0] MODE_HEAT = 3'h2;
    localparam logic [2:0] MODE_CHARGER = 3'h3;
    localparam logic [2:0] MODE_EVENTS = 3'h4;
    localparam logic [2:0] MODE_EXT = 3'h5;

    localparam logic [SOC_W-1:0] SOC_NO_GATE = 7'h05;
    localparam logic [SOC_W-1:0] SOC_FULL = 7'h64;
    localparam logic [SOC_W-1:0] SOC_ON_RST = 7'h05;
    localparam logic [SOC_W-1:0] SOC_FLOOR_RST = 7'h64;
    localparam logic [31:0] CFG_RST = 32'h0000_0a00;
    localparam logic [PW_W-1:0] P1_RST = 20'h003e8;
    localparam logic [PW_W-1:0] P2_RST = 20'h002bc;
    localparam logic [TIM_T1_W-1:0] T1_RST = 10'h00a;
    localparam logic [TIM_T2_W-1:0] T2_RST = 11'h00a;

    localparam int DARK_HOURS = 3;
    localparam int MIN_PER_HOUR = 60;
    localparam logic [7:0] DARK_MIN = 8'(DARK_HOURS * MIN_PER_HOUR);

    typedef enum logic [2:0] {ST_IDLE, ST_QUAL, ST_ON, ST_HOLD, ST_PAUSE} swo_st_t;
endpackage

// [rtl/swo_ctrl.sv]
// Purpose: four switched outputs driven by power, charge, timers, events
// Assumes: minute_tick_i one-cycle pulse per minute, day_rollover_i at midnight
// Notes: irq status bits 3:0 activation, 7:4 refused by daily limit

module swo_ctrl
    import swo_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [PW_W-1:0] grid_export_w_i,
    input wire logic [PW_W-1:0] pv_power_w_i,
    input wire logic [SOC_W-1:0] battery_soc_i,
    input wire logic inverter_on_i,
    input wire logic fault_i,
    input wire logic [EV_W-1:0] event_i,
    input wire logic minute_tick_i,
    input wire logic day_rollover_i,
    output logic [NCH-1:0] first_switched_output_o,
    output logic battery_discharge_allow_o,
    output logic [SOC_W-1:0] battery_floor_o,
    output logic irq_o
);
    logic ack_r;
    logic [31:0] rdat_r;
    logic wr;
    logic [SOC_W-1:0] soc_on_r;
    logic [SOC_W-1:0] soc_floor_r;
    logic [2*NCH-1:0] irq_stat_r;
    logic [2*NCH-1:0] irq_en_r;
    logic [2*NCH-1:0] irq_set;
    logic [NCH-1:0] active;
    logic [NCH-1:0] pv_active;
    logic [31:0] ch_rd [NCH];
    logic in_ch;
    logic [1:0] ch_idx;
    logic [1:0] sub;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
            begin
                res[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return res;
    endfunction

    // one-cycle ack; master holds request until ack so ~ack_r avoids a double ack
    assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_r;
    assign in_ch = wb_adr_i >= ADR_CH_BASE;
    assign ch_idx = 2'(wb_adr_i[CH_SHIFT +: 2]);
    assign sub = wb_adr_i[3:2];

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_r <= 1'b0;
        end
        else
        begin
            ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
        end
    end
    assign wb_ack_o = ack_r;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rdat_r <= 32'h0000_0000;
        end
        else if (in_ch)
        begin
            rdat_r <= ch_rd[ch_idx];
        end
        else if (wb_adr_i == ADR_SOC)
        begin
            rdat_r <= {16'h0000, 1'b0, soc_floor_r, 1'b0, soc_on_r};
        end
        else if (wb_adr_i == ADR_STATE)
        begin
            rdat_r <= {24'h00_0000, pv_active, active};
        end
        else if (wb_adr_i == ADR_IRQ_STAT)
        begin
            rdat_r <= {24'h00_0000, irq_stat_r};
        end
        else if (wb_adr_i == ADR_IRQ_EN)
        begin
            rdat_r <= {24'h00_0000, irq_en_r};
        end
        else
        begin
            // unmapped and write-only addresses below 0x40 read zero; addresses from 0x80 up alias the channel blocks
            rdat_r <= 32'h0000_0000;
        end
    end
    assign wb_dat_o = rdat_r;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            soc_on_r <= SOC_ON_RST;
            soc_floor_r <= SOC_FLOOR_RST;
        end
        else if (wr && wb_adr_i == ADR_SOC && wb_sel_i[0])
        begin
            soc_on_r <= wb_dat_i[SOC_ON_LO +: SOC_W];
            if (wb_sel_i[1])
            begin
                soc_floor_r <= wb_dat_i[SOC_FLOOR_LO +: SOC_W];
            end
        end
        else if (wr && wb_adr_i == ADR_SOC && wb_sel_i[1])
        begin
            soc_floor_r <= wb_dat_i[SOC_FLOOR_LO +: SOC_W];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_en_r <= '0;
        end
        else if (wr && wb_adr_i == ADR_IRQ_EN && wb_sel_i[0])
        begin
            irq_en_r <= wb_dat_i[2*NCH-1:0];
        end
    end

    // set wins over a clear written in the same cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_stat_r <= '0;
        end
        else if (wr && wb_adr_i == ADR_IRQ_CLR && wb_sel_i[0])
        begin
            irq_stat_r <= (irq_stat_r & ~wb_dat_i[2*NCH-1:0]) | irq_set;
        end
        else
        begin
            irq_stat_r <= irq_stat_r | irq_set;
        end
    end
    assign irq_o = |(irq_stat_r & irq_en_r);

    // battery may only discharge to the floor while a pv-based output is on
    assign battery_discharge_allow_o = |pv_active & (soc_floor_r < SOC_FULL);
    assign battery_floor_o = soc_floor_r;

    genvar g;
    generate
        for (g = 0; g < NCH; g++)
        begin : g_ch
            logic [31:0] cfg_r;
            logic [PW_W-1:0] p1_r;
            logic [PW_W-1:0] p2_r;
            logic [TIM_T1_W-1:0] t1_r;
            logic [TIM_T2_W-1:0] t2_r;
            swo_st_t st_r;
            logic [CNT_W-1:0] tmr_r;
            logic [CNT_W-1:0] dark_r;
            logic [7:0] day_cnt_r;
            logic out_r;
            logic [2:0] mode;
            logic power_mode;
            logic basis_pv;
            logic [PW_W-1:0] pw;
            logic gate;
            logic trouble;
            logic start_ok;
            logic want;
            logic keep;
            logic start;
            logic act;
            logic wsel;

            assign wsel = wr && in_ch && ch_idx == 2'(g);
            assign mode = cfg_r[CFG_MODE_LO +: 3];
            assign power_mode = mode == MODE_LOAD || mode == MODE_HEAT
                || mode == MODE_CHARGER;
            assign basis_pv = cfg_r[CFG_BASIS];
            assign pw = basis_pv ? pv_power_w_i : grid_export_w_i;
            // 5% threshold means always allowed, whatever the measured charge
            assign gate = !basis_pv || soc_on_r <= SOC_NO_GATE
                || battery_soc_i >= soc_on_r;
            assign trouble = fault_i | ~inverter_on_i;
            assign start_ok = day_cnt_r < cfg_r[CFG_LIM_LO +: 8];
            // function 1 needs power above the limit, function 2 only reaching it
            assign want = power_mode && gate && !trouble
                && (cfg_r[CFG_FUNC] ? pw >= p1_r : pw > p1_r);
            assign keep = !trouble && (!cfg_r[CFG_FUNC] || pw >= p2_r);
            assign start = (cfg_r[CFG_FUNC] ? st_r == ST_IDLE
                : st_r == ST_QUAL && minute_tick_i && tmr_r + 1'b1 >= CNT_W'(t1_r))
                && want && start_ok;
            assign irq_set[g] = start;
            assign irq_set[NCH+g] = st_r == ST_IDLE && want && !start_ok;

            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    cfg_r <= CFG_RST;
                    p1_r <= P1_RST;
                    p2_r <= P2_RST;
                    t1_r <= T1_RST;
                    t2_r <= T2_RST;
                end
                else if (wsel && sub == SUB_CFG)
                begin
                    cfg_r <= merge(cfg_r, wb_dat_i, wb_sel_i);
                end
                else if (wsel && sub == SUB_P1)
                begin
                    p1_r <= PW_W'(merge(32'(p1_r), wb_dat_i, wb_sel_i));
                end
                else if (wsel && sub == SUB_P2)
                begin
                    p2_r <= PW_W'(merge(32'(p2_r), wb_dat_i, wb_sel_i));
                end
                else if (wsel && sub == SUB_TIM)
                begin
                    t1_r <= wb_sel_i[0] ? wb_dat_i[TIM_T1_LO +: TIM_T1_W] : t1_r;
                    t2_r <= wb_sel_i[2] ? wb_dat_i[TIM_T2_LO +: TIM_T2_W] : t2_r;
                end
            end

            assign ch_rd[g] = sub == SUB_CFG ? cfg_r
                : sub == SUB_P1 ? 32'(p1_r)
                : sub == SUB_P2 ? 32'(p2_r)
                : {5'h00, t2_r, 6'h00, t1_r};

            // rollover clears the count but an activation in that cycle still counts
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    day_cnt_r <= 8'h00;
                end
                else if (day_rollover_i)
                begin
                    day_cnt_r <= {7'h00, start};
                end
                else if (start)
                begin
                    day_cnt_r <= day_cnt_r + 8'h01;
                end
            end

            always_ff @(posedge clk_i)
            begin
                if (rst_i || !power_mode)
                begin
                    st_r <= ST_IDLE;
                    tmr_r <= '0;
                    dark_r <= '0;
                end
                else
                begin
                    case (st_r)
                        ST_IDLE:
                        begin
                            tmr_r <= '0;
                            if (start)
                            begin
                                st_r <= ST_ON;
                            end
                            else if (!cfg_r[CFG_FUNC] && want && start_ok)
                            begin
                                st_r <= ST_QUAL;
                            end
                        end
                        ST_QUAL:
                        begin
                            if (!want)
                            begin
                                st_r <= ST_IDLE;
                            end
                            else if (start)
                            begin
                                st_r <= ST_ON;
                                tmr_r <= '0;
                            end
                            else if (minute_tick_i)
                            begin
                                tmr_r <= tmr_r + 1'b1;
                            end
                        end
                        ST_ON:
                        begin
                            if (!cfg_r[CFG_FUNC] && minute_tick_i
                                && tmr_r + 1'b1 >= CNT_W'(t2_r))
                            begin
                                st_r <= ST_IDLE;
                            end
                            else if (!keep || !gate && cfg_r[CFG_FUNC])
                            begin
                                // run time is kept so a resumed run continues
                                st_r <= cfg_r[CFG_HOLD] ? ST_HOLD
                                    : cfg_r[CFG_FUNC] ? ST_IDLE : ST_PAUSE;
                                dark_r <= '0;
                            end
                            else if (!cfg_r[CFG_FUNC] && minute_tick_i)
                            begin
                                tmr_r <= tmr_r + 1'b1;
                            end
                        end
                        ST_HOLD:
                        begin
                            if (keep)
                            begin
                                st_r <= ST_ON;
                            end
                            else if (minute_tick_i)
                            begin
                                // hold delay spans the whole qualify range, hence the wide counter
                                dark_r <= dark_r + 1'b1;
                                if (dark_r + 1'b1 >= CNT_W'(t1_r))
                                begin
                                    st_r <= cfg_r[CFG_FUNC] ? ST_IDLE : ST_PAUSE;
                                end
                            end
                        end
                        ST_PAUSE:
                        begin
                            if (!trouble)
                            begin
                                st_r <= ST_ON;
                            end
                            else if (minute_tick_i)
                            begin
                                dark_r <= dark_r + 1'b1;
                                if (dark_r + 1'b1 >= CNT_W'(DARK_MIN))
                                begin
                                    st_r <= ST_IDLE;
                                end
                            end
                        end
                        default:
                        begin
                            st_r <= ST_IDLE;
                        end
                    endcase
                end
            end

            always_comb
            begin
                if (mode == MODE_EVENTS)
                begin
                    act = |(cfg_r[CFG_EV_LO +: EV_W] & event_i);
                end
                else if (mode == MODE_EXT)
                begin
                    act = cfg_r[CFG_EXT];
                end
                else
                begin
                    act = power_mode && (st_r == ST_ON || st_r == ST_HOLD);
                end
            end

            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    out_r <= 1'b0;
                end
                else
                begin
                    out_r <= act ^ cfg_r[CFG_POL];
                end
            end
            assign first_switched_output_o[g] = out_r;
            assign active[g] = act;
            assign pv_active[g] = act && power_mode && basis_pv;
        end
    endgenerate
endmodule

// [testbench/swo_ctrl_properties.sv]
// Purpose: port-level checks of the switched output controller
// Assumes: one clock, synchronous active-high reset
// Notes: bound to the design from the bench top
module swo_ctrl_properties
    import swo_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [NCH-1:0] first_switched_output_o,
    input wire logic battery_discharge_allow_o,
    input wire logic [SOC_W-1:0] battery_floor_o,
    input wire logic irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_taken;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_wr(a);
        s_taken ##0 (wb_we_i && wb_adr_i == a && wb_sel_i == 4'hf);
    endsequence

    property p_ack_next;
        s_taken |=> wb_ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("request not acked next cycle");
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_ack_cause;
        wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_unmapped_zero;
        s_taken ##0 (!wb_we_i && wb_adr_i == 8'h20) |=> wb_ack_o && wb_dat_o == 32'h0;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
    property p_floor_write;
        logic [SOC_W-1:0] v;
        (s_wr(ADR_SOC), v = wb_dat_i[14:8]) |=> battery_floor_o == v;
    endproperty
    a_floor_write: assert property (p_floor_write) else $error("floor not updated");
    property p_discharge_floor;
        battery_discharge_allow_o |-> battery_floor_o != SOC_FULL;
    endproperty
    a_discharge_floor: assert property (p_discharge_floor) else $error("discharge at full floor");
    // reset itself is the cause here, so this one is never disabled
    property p_reset_state;
        @(posedge clk_i) disable iff (1'b0)
        rst_i |=> first_switched_output_o == '0 && !irq_o && battery_floor_o == SOC_FLOOR_RST;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("bad state after reset");
    property p_irq_mask_off;
        s_wr(ADR_IRQ_EN) ##0 (wb_dat_i[7:0] == 8'h00) |=> !irq_o;
    endproperty
    a_irq_mask_off: assert property (p_irq_mask_off) else $error("irq while all masked");
endmodule

// [testbench/swo_relay_bank.sv]
// Purpose: relay bank on the switched outputs
// Assumes: contact follows coil after SETTLE+1 clock cycles
// Notes: SETTLE 0 models a fast solid-state switch
module swo_relay_bank #(
    parameter int SETTLE = 2
)
(
    input wire logic clk_i,
    input wire logic [3:0] coil_i,
    output logic [3:0] contact_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] pipe [0:SETTLE];
    // mechanical delay: a slow contact lags the coil
    always @(posedge clk_i)
    begin
        pipe[0] <= coil_i;
        for (int i = 1; i <= SETTLE; i++)
            pipe[i] <= pipe[i-1];
    end
    assign contact_o = pipe[SETTLE];
endmodule

// [testbench/swo_ctrl_bench.sv]
// Purpose: self-checking bench of the switched output controller
// Assumes: 125 MHz clock, minute tick driven by the bench
// Notes: read results checked from a queue by a monitor process
module swo_ctrl_bench
    import swo_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack, dis_allow, irq;
    logic inv_on = 1'b1, fault = 1'b0, tick = 1'b0, day = 1'b0;
    logic [ADR_W-1:0] wb_adr = '0;
    logic [31:0] wb_wdat = '0, wb_rdat;
    logic [PW_W-1:0] grid = '0, pv = '0;
    logic [SOC_W-1:0] soc = '0, floor_pct;
    logic [EV_W-1:0] ev = '0, mask;
    logic [NCH-1:0] pins, contacts;
    logic [31:0] seed = 32'h0fd68876;
    logic [31:0] exp_q[$];
    int errors = 0, checks = 0;

    always #4 clk_i = ~clk_i;

    swo_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_wdat),
        .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .grid_export_w_i(grid), .pv_power_w_i(pv),
        .battery_soc_i(soc), .inverter_on_i(inv_on), .fault_i(fault), .event_i(ev),
        .minute_tick_i(tick), .day_rollover_i(day), .first_switched_output_o(pins),
        .battery_discharge_allow_o(dis_allow), .battery_floor_o(floor_pct), .irq_o(irq));
    swo_relay_bank #(.SETTLE(2)) loads (.clk_i(clk_i), .coil_i(pins), .contact_o(contacts));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] ca(input int ch, input logic [1:0] sub);
        return ADR_CH_BASE + 8'(ch << CH_SHIFT) + 8'({sub, 2'b00});
    endfunction
    task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic finish_test();
        if (errors == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // one bus cycle; for a read d is the expected data
    task automatic cyc(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_wdat <= w ? d : 32'h0;
        if (!w)
            exp_q.push_back(d);
        @(posedge clk_i);
        while (wb_ack !== 1'b1 && n < 64)
        begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 64)
            errors++;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic ticks(input int n);
        repeat (n)
        begin
            tick <= 1'b1;
            @(posedge clk_i);
            tick <= 1'b0;
            @(posedge clk_i);
        end
    endtask
    // pins are registered behind the state, so let them settle first
    task automatic pin(input int ch, input logic e);
        step(3);
        check("pin", 32'(pins[ch]), 32'(e));
    endtask

    always @(posedge clk_i)
    begin
        if (wb_ack === 1'b1 && wb_we === 1'b0)
            check("rdat", wb_rdat, exp_q.pop_front());
    end

    initial
    begin
        step(5);
        rst_i <= 1'b0;
        cyc(1'b0, ADR_SOC, 32'h0000_6405);
        for (int c = 0; c < NCH; c++)
        begin
            cyc(1'b0, ca(c, SUB_CFG), CFG_RST);
            cyc(1'b0, ca(c, SUB_P1), 32'(P1_RST));
            cyc(1'b0, ca(c, SUB_P2), 32'(P2_RST));
            cyc(1'b0, ca(c, SUB_TIM), 32'h000a_000a);
        end
        cyc(1'b0, 8'h20, 32'h0);
        check("floor", 32'(floor_pct), 32'h64);
        cyc(1'b1, ca(1, SUB_CFG), 32'h0000_0a21);
        cyc(1'b1, ca(2, SUB_CFG), 32'h0000_0a29);
        pin(1, 1'b0);
        pin(2, 1'b1);
        grid <= P1_RST + 20'(rnd() % 20000);
        pin(1, 1'b1);
        pin(2, 1'b0);
        grid <= P2_RST;
        pin(1, 1'b1);
        grid <= P2_RST - 20'h1;
        pin(1, 1'b0);
        pin(2, 1'b1);
        grid <= '0;
        cyc(1'b1, ADR_SOC, 32'h0000_1e32);
        cyc(1'b1, ca(0, SUB_CFG), 32'h0000_0a31);
        soc <= 7'h28;
        pv <= 20'h7d0;
        pin(0, 1'b0);
        check("dis", 32'(dis_allow), 32'h0);
        soc <= 7'h32;
        pin(0, 1'b1);
        check("dis", 32'(dis_allow), 32'h1);
        cyc(1'b1, ADR_SOC, 32'h0000_6432);
        check("dis", 32'(dis_allow), 32'h0);
        pv <= '0;
        cyc(1'b1, ADR_IRQ_EN, 32'h0);
        cyc(1'b1, ADR_IRQ_CLR, 32'hff);
        cyc(1'b1, ca(3, SUB_P1), 32'h64);
        cyc(1'b1, ca(3, SUB_TIM), 32'h0003_0002);
        cyc(1'b1, ca(3, SUB_CFG), 32'h0000_0101);
        grid <= 20'h1f4;
        // a tick in the same cycle as the power step is not a full minute above
        step(2);
        ticks(1);
        pin(3, 1'b0);
        ticks(1);
        pin(3, 1'b1);
        ticks(2);
        pin(3, 1'b1);
        ticks(1);
        pin(3, 1'b0);
        ticks(3);
        pin(3, 1'b0);
        check("irq", 32'(irq), 32'h0);
        cyc(1'b1, ADR_IRQ_EN, 32'h80);
        check("irq", 32'(irq), 32'h1);
        cyc(1'b0, ADR_IRQ_STAT, 32'h88);
        day <= 1'b1;
        @(posedge clk_i);
        day <= 1'b0;
        ticks(3);
        pin(3, 1'b1);
        cyc(1'b1, ADR_IRQ_CLR, 32'hff);
        check("irq", 32'(irq), 32'h0);
        grid <= '0;
        for (int i = 0; i < 3; i++)
        begin
            mask = 8'(rnd()) | 8'h01;
            cyc(1'b1, ca(1, SUB_CFG), {8'h00, mask, 8'h0a, 8'h04});
            ev <= 8'(rnd()) & ~mask;
            pin(1, 1'b0);
            ev <= mask & (~mask + 8'h01);
            pin(1, 1'b1);
        end
        ev <= '0;
        cyc(1'b1, ca(2, SUB_CFG), 32'h0000_0a85);
        pin(2, 1'b1);
        cyc(1'b1, ca(2, SUB_CFG), 32'h0000_0a05);
        pin(2, 1'b0);
        cyc(1'b1, ca(1, SUB_P1), 32'h000f_3e58);
        cyc(1'b1, ca(1, SUB_TIM), 32'h000a_0003);
        cyc(1'b1, ca(1, SUB_CFG), 32'h0000_0a61);
        grid <= 20'hf3e57;
        pin(1, 1'b0);
        grid <= 20'hf3e58;
        pin(1, 1'b1);
        fault <= 1'b1;
        ticks(1);
        pin(1, 1'b1);
        fault <= 1'b0;
        ticks(4);
        pin(1, 1'b1);
        grid <= '0;
        step(2);
        ticks(2);
        pin(1, 1'b1);
        ticks(1);
        pin(1, 1'b0);
        cyc(1'b1, ca(3, SUB_CFG), 32'h0000_0301);
        grid <= 20'h1f4;
        step(2);
        ticks(2);
        pin(3, 1'b1);
        inv_on <= 1'b0;
        ticks(1);
        pin(3, 1'b0);
        inv_on <= 1'b1;
        pin(3, 1'b1);
        inv_on <= 1'b0;
        ticks(181);
        inv_on <= 1'b1;
        pin(3, 1'b0);
        grid <= '0;
        step(4);
        check("relay", 32'(contacts), 32'(pins));
        finish_test();
    end

    initial
    begin
        step(5000);
        errors++;
        finish_test();
    end
endmodule

bind swo_ctrl swo_ctrl_properties u_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .first_switched_output_o(first_switched_output_o),
    .battery_discharge_allow_o(battery_discharge_allow_o),
    .battery_floor_o(battery_floor_o), .irq_o(irq_o));
